// >>> rtl/tmr_regs.svh
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_TCON 8'h88
`define IDX_MODE 8'h89
`define IDX_T0_LOW 8'h8A
`define IDX_T0_HIGH 8'h8C
`define IDX_AUX 8'h8E
`define IDX_CLKO 8'h8F
`define IDX_IRQ_EN 8'hA8
`define IDX_IRQ_EN2 8'hAF
`define IDX_IRQ_PRIO 8'hB8
`define IDX_T34M 8'hD1
`define IDX_T4_HIGH 8'hD2
`define IDX_T4_LOW 8'hD3
`define IDX_T3_HIGH 8'hD4
`define IDX_T3_LOW 8'hD5
`define IDX_T34_STAT 8'hD6

// Field positions
`define TCON_RUN0 4
`define TCON_OVF0 5
`define MODE_GATE1 7
`define MODE_GATE0 3
`define MODE_SRC0 2
`define MODE_M1 1
`define MODE_M0 0
`define AUX_BYP0 7
`define CLKO_T0 0
`define EN_GLOBAL 7
`define EN_T1 3
`define EN_T0 1
`define EN2_T4 6
`define EN2_T3 5
`define EN2_T2 2
`define EN2_RSVD 7
`define PRIO_T1 3
`define PRIO_T0 1

// Values
`define MODE_AR16 2'b00
`define REG_RESET 8'h00
`define CNT_RESET 16'h0000
`define CNT_MAX 16'hFFFF
`define DIV12_LAST 4'hB
`define DIV_RESET 4'h0

// Interrupt source slots
`define SRC_T0 0
`define SRC_T1 1
`define SRC_T2 2
`define SRC_T3 3
`define SRC_T4 4

`endif

// >>> rtl/tmr_pkg.sv
package tmr_pkg;

   // One nibble of the timer 3/4 mode register
   typedef struct packed {
      logic run;
      logic source_select;
      logic prescale_bypass;
      logic clock_out_enable;
   } t34_ctl_t;

   // One clock-output pin: level and drive enable
   typedef struct packed {
      logic level;
      logic oe;
   } clk_pin_t;

endpackage

// >>> rtl/autoreload_timer_with_irq_control.sv
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "tmr_regs.svh"

module autoreload_timer_with_irq_control
   import tmr_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int NSRC = 5
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_irq0_pin,
   input wire logic tmr0_count_pin,
   input wire logic tmr3_count_pin,
   input wire logic tmr4_count_pin,
   input wire logic tmr1_flag,
   input wire logic tmr2_flag,
   input wire logic [NSRC-1:0] irq_ack,
   output logic [NSRC-1:0] irq_req,
   output logic [NSRC-1:0] irq_high,
   output logic tmr0_clk_out,
   output logic tmr0_clk_oe,
   output logic tmr3_clk_out,
   output logic tmr3_clk_oe,
   output logic tmr4_clk_out,
   output logic tmr4_clk_oe,
   output logic tmr1_gate
);

   logic [7:0] tcon_r;
   logic [7:0] timer_mode_register_r;
   logic [7:0] auxiliary_control_r;
   logic [7:0] clock_output_control_r;
   logic [7:0] interrupt_enable_r;
   logic [7:0] interrupt_enable_2_r;
   logic [7:0] interrupt_priority_r;
   logic [7:0] timer34_mode_r;
   logic [15:0] tmr0_count_r;
   logic [7:0] tmr0_reload_low_r;
   logic [7:0] tmr0_reload_high_r;
   logic [15:0] t34_cnt_r [2];
   logic [15:0] t34_rl_r [2];
   logic [1:0] t34_flag_r;
   logic [3:0] div_r;
   logic div_tick;
   logic [2:0] pin_prev_r;
   logic [2:0] pin_fall;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic [7:0] rd_data;
   logic rd_hit;
   logic [7:0] idx;
   logic addr_ok;
   logic wr_en;
   logic [7:0] wbyte;
   logic t0_cnt_en;
   logic t0_tick;
   logic t0_ovf;
   logic [1:0] t34_tick;
   logic [1:0] t34_ovf;
   t34_ctl_t t34_ctl [2];
   clk_pin_t pin0_r;
   clk_pin_t pin34_r [2];
   logic [NSRC-1:0] irq_req_r;
   logic [NSRC-1:0] irq_high_r;
   logic [NSRC-1:0] src_flag;
   logic [NSRC-1:0] src_en;

   // Counter step: pin edge, every clock, or the divided enable
   function automatic logic tick_sel(input logic ext, input logic byp,
                                     input logic fall, input logic div);
      if (ext) begin
         tick_sel = fall;
      end else if (byp) begin
         tick_sel = 1'b1;
      end else begin
         tick_sel = div;
      end
   endfunction

   // Register index from the byte address
   function automatic logic [7:0] addr_idx(input logic [ADDR_W-1:0] a);
      addr_idx = a[9:2];
   endfunction

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign irq_req = irq_req_r;
   assign irq_high = irq_high_r;
   assign tmr0_clk_out = pin0_r.level;
   assign tmr0_clk_oe = pin0_r.oe;
   assign tmr3_clk_out = pin34_r[0].level;
   assign tmr3_clk_oe = pin34_r[0].oe;
   assign tmr4_clk_out = pin34_r[1].level;
   assign tmr4_clk_oe = pin34_r[1].oe;
   assign tmr1_gate = timer_mode_register_r[`MODE_GATE1];

   // Shared divide-by-12 enable for all prescaled timers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= `DIV_RESET;
      end else if (div_r == `DIV12_LAST) begin
         div_r <= `DIV_RESET;
      end else begin
         div_r <= div_r + 4'h1;
      end
   end
   assign div_tick = (div_r == `DIV12_LAST);

   // Count pins are synchronous; a count is a high-to-low edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_prev_r <= 3'h0;
      end else begin
         pin_prev_r <= {tmr4_count_pin, tmr3_count_pin, tmr0_count_pin};
      end
   end
   assign pin_fall = pin_prev_r &
                     ~{tmr4_count_pin, tmr3_count_pin, tmr0_count_pin};

   // APB decode
   assign idx = addr_idx(paddr);
   assign addr_ok = (paddr[1:0] == 2'b00) &&
                    (paddr[ADDR_W-1:10] == '0);
   assign wr_en = psel & penable & pready_r & pwrite & ~pslverr_r;
   assign wbyte = pwdata[7:0];

   always_comb begin
      rd_data = 8'h00;
      rd_hit = addr_ok;
      if (idx == `IDX_TCON) begin
         rd_data = tcon_r;
      end else if (idx == `IDX_MODE) begin
         rd_data = timer_mode_register_r;
      end else if (idx == `IDX_T0_LOW) begin
         rd_data = tmr0_count_r[7:0];
      end else if (idx == `IDX_T0_HIGH) begin
         rd_data = tmr0_count_r[15:8];
      end else if (idx == `IDX_AUX) begin
         rd_data = auxiliary_control_r;
      end else if (idx == `IDX_CLKO) begin
         rd_data = clock_output_control_r;
      end else if (idx == `IDX_IRQ_EN) begin
         rd_data = interrupt_enable_r;
      end else if (idx == `IDX_IRQ_EN2) begin
         rd_data = interrupt_enable_2_r;
      end else if (idx == `IDX_IRQ_PRIO) begin
         rd_data = interrupt_priority_r;
      end else if (idx == `IDX_T34M) begin
         rd_data = timer34_mode_r;
      end else if (idx == `IDX_T4_HIGH) begin
         rd_data = t34_cnt_r[1][15:8];
      end else if (idx == `IDX_T4_LOW) begin
         rd_data = t34_cnt_r[1][7:0];
      end else if (idx == `IDX_T3_HIGH) begin
         rd_data = t34_cnt_r[0][15:8];
      end else if (idx == `IDX_T3_LOW) begin
         rd_data = t34_cnt_r[0][7:0];
      end else if (idx == `IDX_T34_STAT) begin
         rd_data = {6'h00, t34_flag_r};
      end else begin
         rd_hit = 1'b0;
      end
   end

   // One wait-free access phase: data and pready set up in setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= psel & ~penable;
         if (psel & ~penable) begin
            pslverr_r <= ~rd_hit;
            prdata_r <= {24'h00_0000, rd_data};
         end
      end
   end

   // Plain control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_mode_register_r <= `REG_RESET;
         auxiliary_control_r <= `REG_RESET;
         clock_output_control_r <= `REG_RESET;
         interrupt_enable_r <= `REG_RESET;
         interrupt_enable_2_r <= `REG_RESET;
         interrupt_priority_r <= `REG_RESET;
         timer34_mode_r <= `REG_RESET;
      end else if (wr_en) begin
         if (idx == `IDX_MODE) begin
            timer_mode_register_r <= wbyte;
         end else if (idx == `IDX_AUX) begin
            auxiliary_control_r <= wbyte;
         end else if (idx == `IDX_CLKO) begin
            clock_output_control_r <= wbyte;
         end else if (idx == `IDX_IRQ_EN) begin
            interrupt_enable_r <= wbyte;
         end else if (idx == `IDX_IRQ_EN2) begin
            // Top bit is reserved and reads zero
            interrupt_enable_2_r <= {1'b0, wbyte[6:0]};
         end else if (idx == `IDX_IRQ_PRIO) begin
            interrupt_priority_r <= wbyte;
         end else if (idx == `IDX_T34M) begin
            timer34_mode_r <= wbyte;
         end
      end
   end

   // Timer 0 gating and stepping
   assign t0_cnt_en = tcon_r[`TCON_RUN0] &
                      (~timer_mode_register_r[`MODE_GATE0] |
                       ext_irq0_pin) &
                      (timer_mode_register_r[`MODE_M1:`MODE_M0] ==
                       `MODE_AR16);
   assign t0_tick = t0_cnt_en &
                    tick_sel(timer_mode_register_r[`MODE_SRC0],
                             auxiliary_control_r[`AUX_BYP0],
                             pin_fall[0], div_tick);
   assign t0_ovf = t0_tick & (tmr0_count_r == `CNT_MAX);

   // Hidden reload bytes always take the written value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmr0_reload_low_r <= `REG_RESET;
         tmr0_reload_high_r <= `REG_RESET;
      end else if (wr_en) begin
         if (idx == `IDX_T0_LOW) begin
            tmr0_reload_low_r <= wbyte;
         end else if (idx == `IDX_T0_HIGH) begin
            tmr0_reload_high_r <= wbyte;
         end
      end
   end

   // Live count: writes reach it only while stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmr0_count_r <= `CNT_RESET;
      end else if (wr_en && !tcon_r[`TCON_RUN0] &&
                   idx == `IDX_T0_LOW) begin
         tmr0_count_r[7:0] <= wbyte;
      end else if (wr_en && !tcon_r[`TCON_RUN0] &&
                   idx == `IDX_T0_HIGH) begin
         tmr0_count_r[15:8] <= wbyte;
      end else if (t0_ovf) begin
         tmr0_count_r <= {tmr0_reload_high_r,
                          tmr0_reload_low_r};
      end else if (t0_tick) begin
         tmr0_count_r <= tmr0_count_r + 16'h0001;
      end
   end

   // Run and overflow flag; an overflow beats a clear in one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tcon_r <= `REG_RESET;
      end else begin
         if (wr_en && idx == `IDX_TCON) begin
            tcon_r <= wbyte;
         end else if (irq_ack[`SRC_T0]) begin
            tcon_r[`TCON_OVF0] <= 1'b0;
         end
         if (t0_ovf) begin
            tcon_r[`TCON_OVF0] <= 1'b1;
         end
      end
   end

   // Timer 0 square wave appears on the timer 1 pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin0_r <= '0;
      end else begin
         pin0_r.oe <= clock_output_control_r[`CLKO_T0];
         if (t0_ovf && clock_output_control_r[`CLKO_T0]) begin
            pin0_r.level <= ~pin0_r.level;
         end
      end
   end

   // Timers 3 and 4: slot 0 is timer 3, slot 1 is timer 4
   assign t34_ctl[0] = t34_ctl_t'(timer34_mode_r[3:0]);
   assign t34_ctl[1] = t34_ctl_t'(timer34_mode_r[7:4]);

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         t34_tick[i] = t34_ctl[i].run &
                       tick_sel(t34_ctl[i].source_select,
                                t34_ctl[i].prescale_bypass,
                                pin_fall[i+1], div_tick);
         t34_ovf[i] = t34_tick[i] & (t34_cnt_r[i] == `CNT_MAX);
      end
   end

   // Same hidden-reload write steering as timer 0
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 2; i++) begin
            t34_cnt_r[i] <= `CNT_RESET;
            t34_rl_r[i] <= `CNT_RESET;
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (t34_ovf[i]) begin
               t34_cnt_r[i] <= t34_rl_r[i];
            end else if (t34_tick[i]) begin
               t34_cnt_r[i] <= t34_cnt_r[i] + 16'h0001;
            end
         end
         if (wr_en && idx == `IDX_T3_LOW) begin
            t34_rl_r[0][7:0] <= wbyte;
            if (!t34_ctl[0].run) begin
               t34_cnt_r[0][7:0] <= wbyte;
            end
         end else if (wr_en && idx == `IDX_T3_HIGH) begin
            t34_rl_r[0][15:8] <= wbyte;
            if (!t34_ctl[0].run) begin
               t34_cnt_r[0][15:8] <= wbyte;
            end
         end else if (wr_en && idx == `IDX_T4_LOW) begin
            t34_rl_r[1][7:0] <= wbyte;
            if (!t34_ctl[1].run) begin
               t34_cnt_r[1][7:0] <= wbyte;
            end
         end else if (wr_en && idx == `IDX_T4_HIGH) begin
            t34_rl_r[1][15:8] <= wbyte;
            if (!t34_ctl[1].run) begin
               t34_cnt_r[1][15:8] <= wbyte;
            end
         end
      end
   end

   // Timer 3/4 flags and clock pins; set wins over acknowledge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t34_flag_r <= 2'b00;
         for (int i = 0; i < 2; i++) begin
            pin34_r[i] <= '0;
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (t34_ovf[i]) begin
               t34_flag_r[i] <= 1'b1;
            end else if (irq_ack[`SRC_T3+i]) begin
               t34_flag_r[i] <= 1'b0;
            end
            pin34_r[i].oe <= t34_ctl[i].clock_out_enable;
            if (t34_ovf[i] && t34_ctl[i].clock_out_enable) begin
               pin34_r[i].level <= ~pin34_r[i].level;
            end
         end
      end
   end

   // Interrupt qualification
   assign src_flag = {t34_flag_r, tmr2_flag, tmr1_flag,
                      tcon_r[`TCON_OVF0]};
   assign src_en = {interrupt_enable_2_r[`EN2_T4],
                    interrupt_enable_2_r[`EN2_T3],
                    interrupt_enable_2_r[`EN2_T2],
                    interrupt_enable_r[`EN_T1],
                    interrupt_enable_r[`EN_T0]};

   // Registered requests add one cycle of latency after the flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_req_r <= '0;
         irq_high_r <= '0;
      end else begin
         irq_req_r <= src_flag & src_en &
                      {NSRC{interrupt_enable_r[`EN_GLOBAL]}};
         // Timers 2-4 have no priority bit and stay at level 0
         irq_high_r <= {3'b000, interrupt_priority_r[`PRIO_T1],
                        interrupt_priority_r[`PRIO_T0]};
      end
   end

endmodule

// >>> tb/tmr_asserts.sv
`timescale 1ns/1ps
`include "tmr_regs.svh"
module tmr_asserts
   import tmr_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int NSRC = 5
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic ext_irq0_pin,
   input wire logic tmr1_flag,
   input wire logic [NSRC-1:0] irq_req,
   input wire logic [NSRC-1:0] irq_high,
   input wire logic tmr0_clk_out,
   input wire logic tmr0_clk_oe,
   input wire logic tmr3_clk_out,
   input wire logic tmr3_clk_oe,
   input wire logic tmr4_clk_out,
   input wire logic tmr4_clk_oe,
   input wire logic tmr1_gate
);
   // Shadow copies follow accepted writes, so checks need no peeking inside
   logic [7:0] tcon_r, mode_r, clko_r, en_r, en2_r, prio_r, t34_r;
   logic [2:0] oe_want;
   logic [1:0] prio_want;
   logic wr_hit;
   assign wr_hit = psel && penable && pready && pwrite && paddr[1:0] == 2'h0;
   assign oe_want = {t34_r[4], t34_r[0], clko_r[`CLKO_T0]};
   assign prio_want = {prio_r[`PRIO_T1], prio_r[`PRIO_T0]};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {tcon_r, mode_r, clko_r, en_r} <= 32'h0;
         {en2_r, prio_r, t34_r} <= 24'h0;
      end else if (wr_hit) begin
         case (paddr[9:2])
            `IDX_TCON: tcon_r <= pwdata[7:0];
            `IDX_MODE: mode_r <= pwdata[7:0];
            `IDX_CLKO: clko_r <= pwdata[7:0];
            `IDX_IRQ_EN: en_r <= pwdata[7:0];
            `IDX_IRQ_EN2: en2_r <= pwdata[7:0];
            `IDX_IRQ_PRIO: prio_r <= pwdata[7:0];
            `IDX_T34M: t34_r <= pwdata[7:0];
            default: ;
         endcase
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   // Gate pin may pass a synchroniser, so it must stay low a while
   sequence gate_shut_s;
      (mode_r[`MODE_GATE0] && !ext_irq0_pin) [*3];
   endsequence
   sequence t1_live_s;
      (en_r[`EN_GLOBAL] && en_r[`EN_T1] && tmr1_flag) [*2];
   endsequence
   ready_after_setup_a: assert property (setup_s |=> pready)
      else $error("pready missing after setup");
   ready_single_a: assert property (pready |=> !pready)
      else $error("pready held too long");
   global_gate_a: assert property (
      !en_r[`EN_GLOBAL] |=> irq_req == '0)
      else $error("request with global enable clear");
   t0_enable_a: assert property (!en_r[`EN_T0] |=> !irq_req[0])
      else $error("timer 0 request while disabled");
   prio_map_a: assert property (irq_high[1:0] == $past(prio_want))
      else $error("priority output wrong");
   t3_halt_a: assert property (!t34_r[3] |=> $stable(tmr3_clk_out))
      else $error("timer 3 moved while stopped");
   t4_halt_a: assert property (!t34_r[7] |=> $stable(tmr4_clk_out))
      else $error("timer 4 moved while stopped");
   t4_enable_a: assert property (!en2_r[`EN2_T4] |=> !irq_req[4])
      else $error("timer 4 request while disabled");
   t0_mode_a: assert property (
      mode_r[`MODE_M1:`MODE_M0] != `MODE_AR16 |=> $stable(tmr0_clk_out))
      else $error("timer 0 moved outside mode 0");
   t0_gated_a: assert property (gate_shut_s |=> $stable(tmr0_clk_out))
      else $error("timer 0 moved while gated");
   t0_halt_a: assert property (
      !tcon_r[`TCON_RUN0] |=> $stable(tmr0_clk_out))
      else $error("timer 0 moved while stopped");
   gate_bit_a: assert property (tmr1_gate == mode_r[`MODE_GATE1])
      else $error("timer 1 gate output wrong");
   oe_follow_a: assert property (
      {tmr4_clk_oe, tmr3_clk_oe, tmr0_clk_oe} == $past(oe_want))
      else $error("clock output enable wrong");
   t1_request_a: assert property (t1_live_s |=> irq_req[1])
      else $error("timer 1 request missing");
endmodule

bind autoreload_timer_with_irq_control tmr_asserts #(
   .ADDR_W(ADDR_W),
   .NSRC(NSRC)
) i_tmr_asserts (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .ext_irq0_pin(ext_irq0_pin), .tmr1_flag(tmr1_flag),
   .irq_req(irq_req), .irq_high(irq_high),
   .tmr0_clk_out(tmr0_clk_out), .tmr0_clk_oe(tmr0_clk_oe),
   .tmr3_clk_out(tmr3_clk_out), .tmr3_clk_oe(tmr3_clk_oe),
   .tmr4_clk_out(tmr4_clk_out), .tmr4_clk_oe(tmr4_clk_oe),
   .tmr1_gate(tmr1_gate)
);

// >>> tb/tmr_pin_model.sv
`timescale 1ns/1ps
module tmr_pin_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic en,
   input wire logic slow,
   output logic [2:0] pins
);
   logic ph_r;
   // Slow mode holds each level two clocks to mimic a slower source
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph_r <= 1'h0;
         pins <= 3'h0;
      end else if (en) begin
         ph_r <= ~ph_r;
         if (!slow || ph_r) begin
            pins <= ~pins;
         end
      end
   end
endmodule

// >>> tb/test_autoreload_timer_with_irq_control.sv
`timescale 1ns/1ps
`include "tmr_regs.svh"
module test_autoreload_timer_with_irq_control
   import tmr_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic ext_irq0_pin, tmr1_flag, tmr2_flag, pin_en, pin_slow, tmr1_gate;
   logic [2:0] pins, cko, coe;
   logic [4:0] irq_ack, irq_req, irq_high;
   int miscompares = 0;
   int n_compared = 0;
   logic [7:0] lo [3] = '{`IDX_T0_LOW, `IDX_T3_LOW, `IDX_T4_LOW};
   logic [7:0] hi [3] = '{`IDX_T0_HIGH, `IDX_T3_HIGH, `IDX_T4_HIGH};
   // Toggles in 120 clocks with reload FFFE: two ticks per toggle
   int ex [5] = '{120 / 12 / 2, 120 / 2, 120 / 2 / 2, 120 / 4 / 2, 0};
   logic [7:0] iev [5] = '{8'h8A, 8'h0A, 8'h88, 8'h82, 8'h80};
   logic [7:0] ie2v [5] = '{8'h64, 8'h64, 8'h00, 8'h40, 8'h24};
   logic [4:0] rqv [5] = '{5'h1F, 5'h00, 5'h02, 5'h11, 5'h0C};
   autoreload_timer_with_irq_control i_autoreload_timer_with_irq_control (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_irq0_pin(ext_irq0_pin),
      .tmr0_count_pin(pins[0]), .tmr3_count_pin(pins[1]),
      .tmr4_count_pin(pins[2]), .tmr1_flag(tmr1_flag),
      .tmr2_flag(tmr2_flag), .irq_ack(irq_ack), .irq_req(irq_req),
      .irq_high(irq_high), .tmr0_clk_out(cko[0]), .tmr0_clk_oe(coe[0]),
      .tmr3_clk_out(cko[1]), .tmr3_clk_oe(coe[1]),
      .tmr4_clk_out(cko[2]), .tmr4_clk_oe(coe[2]), .tmr1_gate(tmr1_gate)
   );
   tmr_pin_model i_tmr_pin_model (
      .pclk(pclk), .presetn(presetn), .en(pin_en), .slow(pin_slow),
      .pins(pins)
   );
   initial begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      {psel, penable, pwrite} <= {1'h1, 1'h0, wr};
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (pready !== 1'h1) miscompares++;
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'h0;
   endtask
   task wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'h1, idx, d);
   endtask
   task rc(input string nm, input logic [7:0] idx, input logic [7:0] e);
      apb(1'h0, idx, 8'h00);
      chk(nm, rd, {24'h0, e});
   endtask
   task settle();
      repeat (3) @(posedge pclk);
   endtask
   task tog(input int s, output int n);
      logic last;
      n = 0;
      @(negedge pclk);
      last = cko[s];
      repeat (120) begin
         @(negedge pclk);
         if (cko[s] !== last) n++;
         last = cko[s];
      end
   endtask
   task end_of_test();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      $display("watchdog expired");
      miscompares++;
      end_of_test();
   end
   initial begin
      t34_ctl_t c;
      int n;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {ext_irq0_pin, tmr1_flag, tmr2_flag, pin_en, pin_slow} = 5'h00;
      irq_ack = 5'h00;
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      rc("irq_en", `IDX_IRQ_EN, 8'h00);
      rc("irq_prio", `IDX_IRQ_PRIO, 8'h00);
      rc("t34m", `IDX_T34M, 8'h00);
      apb(1'h0, 8'h90, 8'h00);
      chk("slverr", {31'h0, err}, 32'h1);
      chk("slverr_data", rd, 32'h0);
      wr(`IDX_IRQ_EN2, 8'hFF);
      rc("irq_en2", `IDX_IRQ_EN2, 8'h7F);
      $display("done: register map");
      for (int t = 0; t < 3; t++) begin
         for (int m = 0; m < 5; m++) begin
            c = {m != 4, m == 2 || m == 3, m == 1 || m == 4, 1'h1};
            pin_en <= c.source_select;
            pin_slow <= (m == 3);
            if (t == 0) begin
               wr(`IDX_MODE, {5'h00, c.source_select, 2'h0});
               wr(`IDX_AUX, {c.prescale_bypass, 7'h00});
               wr(`IDX_CLKO, 8'h01);
            end
            wr(lo[t], 8'hFE);
            wr(hi[t], 8'hFF);
            if (t == 0) wr(`IDX_TCON, {3'h0, c.run, 4'h0});
            else wr(`IDX_T34M, t == 1 ? {4'h0, c} : {c, 4'h0});
            repeat (30) @(posedge pclk);
            chk("clk_oe", coe[t], 1'h1);
            tog(t, n);
            chk("toggles", n, ex[m]);
            wr(t == 0 ? `IDX_TCON : `IDX_T34M, 8'h00);
         end
      end
      $display("done: timer rates");
      wr(`IDX_MODE, 8'h88);
      wr(`IDX_AUX, 8'h80);
      // The write lands at the edge the task returns on
      @(negedge pclk);
      chk("gate1", tmr1_gate, 1'h1);
      wr(`IDX_TCON, 8'h10);
      repeat (30) @(posedge pclk);
      tog(0, n);
      chk("gated", n, 0);
      ext_irq0_pin <= 1'h1;
      repeat (30) @(posedge pclk);
      tog(0, n);
      chk("ungated", n, 120 / 2);
      wr(`IDX_MODE, 8'h89);
      repeat (4) @(posedge pclk);
      tog(0, n);
      chk("mode1", n, 0);
      wr(`IDX_TCON, 8'h20);
      $display("done: gate and mode");
      {tmr1_flag, tmr2_flag} <= 2'h3;
      for (int k = 0; k < 5; k++) begin
         wr(`IDX_IRQ_EN, iev[k]);
         wr(`IDX_IRQ_EN2, ie2v[k]);
         settle();
         chk("irq_req", irq_req, rqv[k]);
      end
      for (int k = 0; k < 3; k++) begin
         wr(`IDX_IRQ_PRIO, 8'h0A >> (k * 2));
         settle();
         chk("irq_high", irq_high, 5'h03 >> k);
      end
      rc("status", `IDX_T34_STAT, 8'h03);
      irq_ack <= 5'h09;
      @(posedge pclk);
      irq_ack <= 5'h00;
      wr(`IDX_IRQ_EN, 8'h82);
      settle();
      chk("acked", irq_req, 5'h04);
      rc("status", `IDX_T34_STAT, 8'h02);
      $display("done: interrupts");
      wr(`IDX_MODE, 8'h00);
      wr(`IDX_TCON, 8'h00);
      wr(`IDX_T0_LOW, 8'hE0);
      wr(`IDX_T0_HIGH, 8'hFF);
      rc("t0_low", `IDX_T0_LOW, 8'hE0);
      wr(`IDX_TCON, 8'h10);
      wr(`IDX_T0_LOW, 8'h55);
      wr(`IDX_T0_HIGH, 8'hAA);
      rc("t0_high", `IDX_T0_HIGH, 8'hFF);
      repeat (60) @(posedge pclk);
      rc("tcon", `IDX_TCON, 8'h30);
      rc("t0_high", `IDX_T0_HIGH, 8'hAA);
      chk("t0_irq", irq_req[0], 1'h1);
      wr(`IDX_TCON, 8'h00);
      $display("done: reload");
      end_of_test();
   end
endmodule
